// >>> rtl/mdiomm_dev.sv
// device end of the management link: frame decode, read drive, the two
// indirect-access registers and a user port onto the direct set and three indirect spaces
// assumes mdc and mdio are asynchronous pins, sampled by core_clk
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns

// How it works
// - controller keeps mdc slow, may stop it
// - line is sampled on mdc rising edge
// - bus address latched from straps at reset
// - controller stays quiet after power-up and reset
// - direct frames address 32 sixteen-bit registers
// - frame starts with zero-one after idle high
// - read turnaround: released, then zero, then data
// - write turnaround one-zero from controller only
// - indirect control and window registers
// - window reaches standard registers except those two
// - control low bits select the space
// - only three space selectors are accepted
// - control top bits select window function
// - address function reaches the pointer
// - data function reaches register, no increment
// - software loads the pointer first
// - controller sequence for extended access
module mdiomm_dev
(
  input  wire logic        core_clk,   // core clock
  input  wire logic        rst_n,      // synchronous reset
  input  wire logic        clkEn,      // freezes all state when low
  mdiomm_if.dev            lnk,        // management link
  input  wire logic [2:0]  strapAddr,  // address strap pins
  output logic      [4:0]  accSel,     // target space, 0 for direct set
  output logic      [15:0] accAddr,    // register address in that space
  output logic      [15:0] accWdata,   // write data
  output logic             accWr,      // write pulse
  output logic             accRd,      // read pulse
  input  wire logic [15:0] accRdata    // read data, cycle after accRd
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed
  {
    logic                     mdcS1;
    logic                     mdcS2;
    logic                     mdcS3;
    logic                     mdioS1;
    logic                     mdioS2;
    logic [2:0]               strapS1;
    logic [2:0]               strapS2;
    logic [2:0]               phyAddr;
    mdiomm_pkg::mdiomm_dev_st_e st;
    logic [4:0]               bitCnt;
    logic [15:0]              shift;
    logic [1:0]               op;
    logic                     hit;
    logic [4:0]               regIdx;
    logic [15:0]              rdWord;
    logic                     rdPend;
    logic [15:0]              accessCtrl;
    logic [15:0]              pointer;
    logic                     mdioOut;
    logic                     mdioOe;
    logic [4:0]               accSel;
    logic [15:0]              accAddr;
    logic [15:0]              accWdata;
    logic                     accWr;
    logic                     accRd;
  } mdiomm_dev_s;

  mdiomm_dev_s s_reg;
  mdiomm_dev_s s_next;

  // ************************************************************
  // helpers
  // ************************************************************
  // where a window access lands for a given control word and pointer
  function automatic mdiomm_pkg::mdiomm_win_e winTarget(input logic [15:0] ctrl, input logic [15:0] ptr);
    logic [4:0] sel;
    logic [1:0] fn;
    sel = ctrl[mdiomm_pkg::SEL_HI:mdiomm_pkg::SEL_LO];
    fn  = ctrl[mdiomm_pkg::FUNC_HI:mdiomm_pkg::FUNC_LO];
    winTarget = mdiomm_pkg::WIN_IGNORE;
    if (sel == mdiomm_pkg::SPACE_VENDOR || sel == mdiomm_pkg::SPACE_EEE_A || sel == mdiomm_pkg::SPACE_EEE_B)
    begin
      if (fn == mdiomm_pkg::FUNC_ADDR)
        winTarget = mdiomm_pkg::WIN_POINTER;
      else if (fn == mdiomm_pkg::FUNC_DATA)
      begin
        if (sel == mdiomm_pkg::SPACE_VENDOR && ptr < mdiomm_pkg::STD_REG_COUNT)
        begin
          // the two indirect registers are never reached through themselves
          if (ptr[4:0] != mdiomm_pkg::REG_ACCESS_CTRL && ptr[4:0] != mdiomm_pkg::REG_ADDR_DATA_WIN)
            winTarget = mdiomm_pkg::WIN_STD;
        end
        else
          winTarget = mdiomm_pkg::WIN_EXT;
      end
    end
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    logic                    rise;
    logic                    bitIn;
    logic [4:0]              idx;
    logic [11:0]             hdr;
    logic [15:0]             data;
    mdiomm_pkg::mdiomm_win_e tgt;
    s_next = s_reg;
    rise   = s_reg.mdcS2 & ~s_reg.mdcS3;
    bitIn  = s_reg.mdioS2;
    idx    = s_reg.bitCnt + 5'h01;
    hdr    = {s_reg.shift[10:0], bitIn};
    data   = {s_reg.shift[14:0], bitIn};
    tgt    = winTarget(s_reg.accessCtrl, s_reg.pointer);

    // two-flop synchronisers; first stage feeds only the second
    s_next.mdcS1   = lnk.mdc;
    s_next.mdcS2   = s_reg.mdcS1;
    s_next.mdcS3   = s_reg.mdcS2;
    s_next.mdioS1  = lnk.mdio;
    s_next.mdioS2  = s_reg.mdioS1;
    s_next.strapS1 = strapAddr;
    s_next.strapS2 = s_reg.strapS1;
    s_next.accWr   = 1'b0;
    s_next.accRd   = 1'b0;

    // user read data stands in the cycle after the accRd pulse, not beside it
    if (s_reg.rdPend && !s_reg.accRd)
    begin
      s_next.rdWord = accRdata;
      s_next.rdPend = 1'b0;
    end

    // mdc may stop at any time, so all frame progress waits on its edges
    if (rise)
    begin
      case (s_reg.st)
        mdiomm_pkg::DEV_IDLE:
          if (bitIn)
            s_next.st = mdiomm_pkg::DEV_ARMED;
        mdiomm_pkg::DEV_ARMED:
          if (!bitIn)
            s_next.st = mdiomm_pkg::DEV_START;
        mdiomm_pkg::DEV_START:
        begin
          // zero-one opens a frame; zero-zero is not a start
          s_next.st     = bitIn ? mdiomm_pkg::DEV_FRAME : mdiomm_pkg::DEV_IDLE;
          s_next.bitCnt = 5'h01;
          s_next.hit    = 1'b0;
          s_next.mdioOe = 1'b0;
        end
        mdiomm_pkg::DEV_FRAME:
        begin
          s_next.bitCnt = idx;
          s_next.shift  = data;
          if (idx == 5'(mdiomm_pkg::FRAME_HDR_LAST))
          begin
            s_next.op     = hdr[11:10];
            s_next.regIdx = hdr[4:0];
            s_next.hit    = hdr[9:5] == {2'h0, s_reg.phyAddr}
                            && (hdr[11:10] == mdiomm_pkg::OP_READ || hdr[11:10] == mdiomm_pkg::OP_WRITE);
            s_next.rdWord = '0;
            if (s_next.hit && hdr[11:10] == mdiomm_pkg::OP_READ)
            begin
              // fetch early: a whole turnaround bit passes before it is needed
              if (hdr[4:0] == mdiomm_pkg::REG_ACCESS_CTRL)
                s_next.rdWord = s_reg.accessCtrl;
              else if (hdr[4:0] == mdiomm_pkg::REG_ADDR_DATA_WIN)
              begin
                if (tgt == mdiomm_pkg::WIN_POINTER)
                  s_next.rdWord = s_reg.pointer;
                else if (tgt != mdiomm_pkg::WIN_IGNORE)
                begin
                  s_next.accSel  = tgt == mdiomm_pkg::WIN_STD ? mdiomm_pkg::SPACE_STD
                                   : s_reg.accessCtrl[mdiomm_pkg::SEL_HI:mdiomm_pkg::SEL_LO];
                  s_next.accAddr = s_reg.pointer;
                  s_next.accRd   = 1'b1;
                  s_next.rdPend  = 1'b1;
                end
              end
              else
              begin
                s_next.accSel  = mdiomm_pkg::SPACE_STD;
                s_next.accAddr = {11'h000, hdr[4:0]};
                s_next.accRd   = 1'b1;
                s_next.rdPend  = 1'b1;
              end
            end
          end
          // first turnaround bit left alone, then zero, then data
          if (s_reg.hit && s_reg.op == mdiomm_pkg::OP_READ)
          begin
            if (idx == 5'(mdiomm_pkg::FRAME_TA1))
            begin
              s_next.mdioOe  = 1'b1;
              s_next.mdioOut = 1'b0;
            end
            else if (idx >= 5'(mdiomm_pkg::FRAME_TA2) && idx < 5'(mdiomm_pkg::FRAME_LAST))
            begin
              s_next.mdioOut = s_reg.rdWord[15];
              s_next.rdWord  = {s_reg.rdWord[14:0], 1'b0};
            end
          end
          if (idx == 5'(mdiomm_pkg::FRAME_LAST))
          begin
            s_next.mdioOe = 1'b0;
            s_next.st     = mdiomm_pkg::DEV_IDLE;
            s_next.hit    = 1'b0;
            // write turnaround and data come from the controller alone
            if (s_reg.hit && s_reg.op == mdiomm_pkg::OP_WRITE)
            begin
              if (s_reg.regIdx == mdiomm_pkg::REG_ACCESS_CTRL)
                s_next.accessCtrl = data;
              else if (s_reg.regIdx == mdiomm_pkg::REG_ADDR_DATA_WIN)
              begin
                if (tgt == mdiomm_pkg::WIN_POINTER)
                  s_next.pointer = data;
                else if (tgt != mdiomm_pkg::WIN_IGNORE)
                begin
                  s_next.accSel   = tgt == mdiomm_pkg::WIN_STD ? mdiomm_pkg::SPACE_STD
                                    : s_reg.accessCtrl[mdiomm_pkg::SEL_HI:mdiomm_pkg::SEL_LO];
                  s_next.accAddr  = s_reg.pointer;
                  s_next.accWdata = data;
                  s_next.accWr    = 1'b1;
                end
              end
              else
              begin
                s_next.accSel   = mdiomm_pkg::SPACE_STD;
                s_next.accAddr  = {11'h000, s_reg.regIdx};
                s_next.accWdata = data;
                s_next.accWr    = 1'b1;
              end
            end
          end
        end
        default:
          s_next.st = mdiomm_pkg::DEV_IDLE;
      endcase
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  // straps follow the pins through reset; phyAddr freezes at its release while the strap flops keep following
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_reg            <= '0;
      s_reg.accessCtrl <= mdiomm_pkg::ACCESS_CTRL_RESET;
      s_reg.pointer    <= mdiomm_pkg::POINTER_RESET;
      s_reg.strapS1    <= strapAddr;
      s_reg.strapS2    <= s_reg.strapS1;
      s_reg.phyAddr    <= s_reg.strapS2;
    end
    else if (clkEn)
      s_reg <= s_next;
  end

  // outputs straight from the state flops
  assign lnk.mdioDev   = s_reg.mdioOut;
  assign lnk.mdioDevOe = s_reg.mdioOe;
  assign accSel        = s_reg.accSel;
  assign accAddr       = s_reg.accAddr;
  assign accWdata      = s_reg.accWdata;
  assign accWr         = s_reg.accWr;
  assign accRd         = s_reg.accRd;

endmodule

// >>> rtl/mdiomm_pkg.sv
// constants, field layouts and state types shared by both ends of the
// management serial link; assumes one 50 MHz core clock at each end
package mdiomm_pkg;

  // ************************************************************
  // frame layout
  // ************************************************************
  localparam logic [1:0] START_PAT      = 2'b01;
  localparam logic [1:0] OP_READ        = 2'b10;
  localparam logic [1:0] OP_WRITE       = 2'b01;
  localparam logic [1:0] TA_WRITE       = 2'b10;
  localparam logic [1:0] TA_READ_IDLE   = 2'b11;
  localparam int         FRAME_HDR_LAST = 13;  // last register-index bit
  localparam int         FRAME_TA1      = 14;
  localparam int         FRAME_TA2      = 15;
  localparam int         FRAME_DATA0    = 16;
  localparam int         FRAME_LAST     = 31;
  localparam int         FRAME_BITS     = 32;
  localparam int         PREAMBLE_BITS  = 32;  // ones ahead of each frame
  localparam logic [2:0] STRAP_PAD      = 3'h0;

  // ************************************************************
  // registers reached over the link
  // ************************************************************
  localparam logic [4:0]  REG_ACCESS_CTRL   = 5'h0D;
  localparam logic [4:0]  REG_ADDR_DATA_WIN = 5'h0E;
  localparam logic [15:0] ACCESS_CTRL_RESET = 16'h0000;
  localparam logic [15:0] POINTER_RESET     = 16'h0000;
  localparam int          SEL_HI            = 4;
  localparam int          SEL_LO            = 0;
  localparam int          FUNC_HI           = 15;
  localparam int          FUNC_LO           = 14;
  localparam logic [1:0]  FUNC_ADDR         = 2'h0;
  localparam logic [1:0]  FUNC_DATA         = 2'h1;
  localparam logic [4:0]  SPACE_STD         = 5'h00;  // user-side tag for the 32 direct registers
  localparam logic [4:0]  SPACE_VENDOR      = 5'h1F;
  localparam logic [4:0]  SPACE_EEE_A       = 5'h03;
  localparam logic [4:0]  SPACE_EEE_B       = 5'h07;
  localparam logic [15:0] STD_REG_COUNT     = 16'h0020;

  // ************************************************************
  // controller command registers
  // ************************************************************
  localparam logic [3:0] CTL_REG_FRAME  = 4'h0;
  localparam logic [3:0] CTL_REG_WDATA  = 4'h1;
  localparam logic [3:0] CTL_REG_STATUS = 4'h2;
  localparam logic [3:0] CTL_REG_RDATA  = 4'h3;
  localparam logic [3:0] CTL_REG_QUIET  = 4'h4;
  localparam int         CMD_READ_BIT   = 10;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CORE_CLK_HZ          = 50_000_000;
  localparam int MDC_MAX_HZ           = 24_000_000;
  localparam int MDC_MIN_HALF         = (CORE_CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);
  localparam int QUIET_POWERUP_MS     = 50;
  localparam int QUIET_RESET_MS       = 2;
  localparam int QUIET_POWERUP_CYCLES = QUIET_POWERUP_MS * (CORE_CLK_HZ / 1000);
  localparam int QUIET_RESET_CYCLES   = QUIET_RESET_MS * (CORE_CLK_HZ / 1000);

  // ************************************************************
  // state types
  // ************************************************************
  typedef enum logic [1:0] {DEV_IDLE, DEV_ARMED, DEV_START, DEV_FRAME} mdiomm_dev_st_e;
  typedef enum logic [1:0] {WIN_IGNORE, WIN_POINTER, WIN_STD, WIN_EXT} mdiomm_win_e;
  typedef enum logic [1:0] {CTL_QUIET, CTL_IDLE, CTL_LOW, CTL_HIGH} mdiomm_ctl_st_e;

endpackage

// >>> rtl/mdiomm_if.sv
// management link between controller and device: clock, shared data line
// assumes the bench or top joins one controller with one device
`timescale 1ns/1ns
interface mdiomm_if;
  logic mdc;        // management clock from controller
  logic mdioCtl;    // controller data out
  logic mdioCtlOe;  // controller drives line
  logic mdioDev;    // device data out
  logic mdioDevOe;  // device drives line
  logic mdio;       // resolved line level

  // pull-up holds the line high whenever nobody drives
  assign mdio = mdioCtlOe ? mdioCtl : (mdioDevOe ? mdioDev : 1'b1);

  modport ctl (output mdc, output mdioCtl, output mdioCtlOe, input mdio);
  modport dev (input mdc, input mdio, output mdioDev, output mdioDevOe);
endinterface

// >>> rtl/mdiomm_ctl.sv
// controller end of the management link: quiet timer, mdc divider and
// frame shifter, ordered through a small register port
// assumes mdio comes back from the pin and is asynchronous to core_clk
`timescale 1ns/1ns
module mdiomm_ctl
#(
  parameter int MDC_HALF_CYCLES      = 8,  // core cycles per mdc half period
  parameter int POWERUP_QUIET_CYCLES = mdiomm_pkg::QUIET_POWERUP_CYCLES,
  parameter int RESET_QUIET_CYCLES   = mdiomm_pkg::QUIET_RESET_CYCLES
)
(
  input  wire logic        core_clk,  // core clock
  input  wire logic        rst_n,     // synchronous reset
  input  wire logic        clkEn,     // freezes all state when low
  mdiomm_if.ctl            lnk,       // management link
  input  wire logic [3:0]  regAddr,   // register address
  input  wire logic [15:0] regWdata,  // write data
  input  wire logic        regWr,     // write strobe
  input  wire logic        regRd,     // read strobe
  output logic      [15:0] regRdata   // read data, cycle after regRd
);

  // mdc never faster than the ceiling, whatever the parameter says
  localparam int HALF = MDC_HALF_CYCLES > mdiomm_pkg::MDC_MIN_HALF ? MDC_HALF_CYCLES : mdiomm_pkg::MDC_MIN_HALF;
  localparam int TOTAL_BITS = mdiomm_pkg::PREAMBLE_BITS + mdiomm_pkg::FRAME_BITS;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed
  {
    mdiomm_pkg::mdiomm_ctl_st_e st;
    logic [21:0]              quietCnt;
    logic [7:0]               phaseCnt;
    logic [5:0]               bitIdx;
    logic [63:0]              frame;
    logic                     isRead;
    logic                     noAck;
    logic [15:0]              rdShift;
    logic [15:0]              rdData;
    logic [15:0]              wdata;
    logic                     mdioS1;
    logic                     mdioS2;
    logic                     mdc;
    logic                     mdioOut;
    logic                     mdioOe;
    logic [15:0]              regRdata;
  } mdiomm_ctl_s;

  mdiomm_ctl_s s_reg;
  mdiomm_ctl_s s_next;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    logic       busy;
    logic       rd;
    logic [5:0] nidx;
    s_next          = s_reg;
    busy            = s_reg.st == mdiomm_pkg::CTL_LOW || s_reg.st == mdiomm_pkg::CTL_HIGH;
    rd              = regWdata[mdiomm_pkg::CMD_READ_BIT];
    nidx            = s_reg.bitIdx + 6'h01;
    s_next.mdioS1   = lnk.mdio;
    s_next.mdioS2   = s_reg.mdioS1;
    s_next.regRdata = '0;

    // register port reads
    if (regRd)
    begin
      case (regAddr)
        mdiomm_pkg::CTL_REG_STATUS: s_next.regRdata = {13'h0000, s_reg.noAck, busy, s_reg.st == mdiomm_pkg::CTL_QUIET};
        mdiomm_pkg::CTL_REG_RDATA:  s_next.regRdata = s_reg.rdData;
        mdiomm_pkg::CTL_REG_WDATA:  s_next.regRdata = s_reg.wdata;
        default:                    s_next.regRdata = '0;
      endcase
    end

    // register port writes; a frame order while busy or quiet is dropped
    if (regWr && regAddr == mdiomm_pkg::CTL_REG_WDATA)
      s_next.wdata = regWdata;
    if (regWr && regAddr == mdiomm_pkg::CTL_REG_QUIET && !busy)
    begin
      s_next.st       = mdiomm_pkg::CTL_QUIET;
      s_next.quietCnt = 22'(RESET_QUIET_CYCLES);
    end
    if (regWr && regAddr == mdiomm_pkg::CTL_REG_FRAME && s_reg.st == mdiomm_pkg::CTL_IDLE)
    begin
      s_next.frame    = {{mdiomm_pkg::PREAMBLE_BITS{1'b1}}, mdiomm_pkg::START_PAT,
                         rd ? mdiomm_pkg::OP_READ : mdiomm_pkg::OP_WRITE, regWdata[9:0],
                         rd ? mdiomm_pkg::TA_READ_IDLE : mdiomm_pkg::TA_WRITE,
                         rd ? 16'hFFFF : s_reg.wdata};
      s_next.isRead   = rd;
      s_next.noAck    = 1'b0;
      s_next.bitIdx   = '0;
      s_next.phaseCnt = '0;
      s_next.mdioOut  = 1'b1;
      s_next.mdioOe   = 1'b1;
      s_next.st       = mdiomm_pkg::CTL_LOW;
    end

    // frame engine; mdc rests low between frames
    case (s_reg.st)
      mdiomm_pkg::CTL_QUIET:
        if (s_reg.quietCnt == '0)
          s_next.st = mdiomm_pkg::CTL_IDLE;
        else
          s_next.quietCnt = s_reg.quietCnt - 22'h000001;
      mdiomm_pkg::CTL_LOW:
        if (s_reg.phaseCnt == 8'(HALF - 1))
        begin
          s_next.mdc      = 1'b1;
          s_next.phaseCnt = '0;
          s_next.st       = mdiomm_pkg::CTL_HIGH;
          // sample on the rising edge; no zero in the second turnaround means no device
          if (s_reg.isRead && s_reg.bitIdx == 6'(mdiomm_pkg::PREAMBLE_BITS + mdiomm_pkg::FRAME_TA2))
            s_next.noAck = s_reg.mdioS2;
          if (s_reg.isRead && s_reg.bitIdx >= 6'(mdiomm_pkg::PREAMBLE_BITS + mdiomm_pkg::FRAME_DATA0))
            s_next.rdShift = {s_reg.rdShift[14:0], s_reg.mdioS2};
        end
        else
          s_next.phaseCnt = s_reg.phaseCnt + 8'h01;
      mdiomm_pkg::CTL_HIGH:
        if (s_reg.phaseCnt == 8'(HALF - 1))
        begin
          s_next.mdc      = 1'b0;
          s_next.phaseCnt = '0;
          if (s_reg.bitIdx == 6'(TOTAL_BITS - 1))
          begin
            s_next.mdioOe  = 1'b0;
            s_next.mdioOut = 1'b1;
            s_next.st      = mdiomm_pkg::CTL_IDLE;
            if (s_reg.isRead)
              s_next.rdData = s_reg.rdShift;
          end
          else
          begin
            s_next.bitIdx  = nidx;
            s_next.frame   = {s_reg.frame[62:0], 1'b1};
            s_next.mdioOut = s_reg.frame[62];
            // released through both turnaround bits and data of a read
            s_next.mdioOe  = !(s_reg.isRead && nidx >= 6'(mdiomm_pkg::PREAMBLE_BITS + mdiomm_pkg::FRAME_TA1));
            s_next.st      = mdiomm_pkg::CTL_LOW;
          end
        end
        else
          s_next.phaseCnt = s_reg.phaseCnt + 8'h01;
      // idle: mdc rests low; a state change here would undo a frame or quiet order
      default:
        s_next.mdc = 1'b0;
    endcase
  end

  // ************************************************************
  // registers
  // ************************************************************
  // quiet period runs from reset release before any frame
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_reg          <= '0;
      s_reg.st       <= mdiomm_pkg::CTL_QUIET;
      s_reg.quietCnt <= 22'(POWERUP_QUIET_CYCLES);
      s_reg.mdioOut  <= 1'b1;
    end
    else if (clkEn)
      s_reg <= s_next;
  end

  assign lnk.mdc       = s_reg.mdc;
  assign lnk.mdioCtl   = s_reg.mdioOut;
  assign lnk.mdioCtlOe = s_reg.mdioOe;
  assign regRdata      = s_reg.regRdata;

endmodule

// >>> tb/mdiomm_sva.sv
// wire checks on the management link between the two ends
// assumes mdc half period of 8 core cycles
`timescale 1ns/1ns
module mdiomm_sva
(
  input wire logic core_clk,  // core clock
  input wire logic rst_n,     // sync reset
  input wire logic mdc,       // link clock
  input wire logic mdioCtl,   // ctl data
  input wire logic mdioCtlOe, // ctl enable
  input wire logic mdioDev,   // dev data
  input wire logic mdioDevOe  // dev enable
);
  // ****
  // link timing and drive
  // ****
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_no_fight: assert property (!(mdioCtlOe && mdioDevOe))
    else $error("both ends drive");
  a_mdc_high: assert property ($rose(mdc) |-> mdc[*8] ##1 !mdc)
    else $error("mdc high time");
  a_mdc_low: assert property ($rose(mdc) |-> !$past(mdc, 8))
    else $error("mdc low time");
  a_ctl_hold: assert property ($rose(mdc) |-> $stable(mdioCtl) && $stable(mdioCtlOe))
    else $error("ctl moves at mdc rise");
  a_dev_hold: assert property ($rose(mdc) |-> $stable(mdioDev) && $stable(mdioDevOe))
    else $error("dev moves at mdc rise");
  a_turn_zero: assert property ($rose(mdioDevOe) |-> !mdioDev && !$past(mdioCtlOe, 8))
    else $error("bad read turnaround");
  a_read_len: assert property ($rose(mdioDevOe) |-> ##250 mdioDevOe ##[1:40] !mdioDevOe)
    else $error("read drive length");
  a_idle_ones: assert property ($rose(mdioCtlOe) |-> mdioCtl[*8])
    else $error("frame lacks idle ones");
endmodule

// >>> tb/mdio_mmd_indirect_access_test.sv
// bench: controller and device joined, register port driven, user port answered
// assumes half period 8 and short quiet times
`timescale 1ns/1ns
module mdio_mmd_indirect_access_test;
  logic        core_clk = 0, rst_n = 0, regWr = 0, regRd = 0, pend = 0, v, ok, accWr, accRd;
  logic [3:0]  regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0, accRdata = 16'h0, regRdata, accWdata, accAddr, last, d, p;
  logic [4:0]  accSel, s, ms, g;
  logic [2:0]  strapAddr = 3'h5;
  logic [31:0] e, qr[$];
  logic [36:0] qw[$];
  int          num_errors = 0, total_checks = 0, seed = 32'h2891, n;
  logic [20:0] tab [6] = '{{5'h1F,16'h0},{5'h03,16'h0},{5'h07,16'h0},{5'h15,16'h0},{5'h1F,16'h5},{5'h1F,16'hD}};
  mdiomm_if lnk ();
  mdiomm_ctl #(.MDC_HALF_CYCLES(8), .POWERUP_QUIET_CYCLES(20), .RESET_QUIET_CYCLES(10)) mdiomm_ctl_i
    (.core_clk, .rst_n, .clkEn(1'b1), .lnk(lnk), .regAddr, .regWdata, .regWr, .regRd, .regRdata);
  mdiomm_dev mdiomm_dev_i (.core_clk, .rst_n, .clkEn(1'b1), .lnk(lnk), .strapAddr, .accSel, .accAddr,
    .accWdata, .accWr, .accRd, .accRdata);
  mdiomm_sva mdiomm_sva_i (.core_clk, .rst_n, .mdc(lnk.mdc), .mdioCtl(lnk.mdioCtl),
    .mdioCtlOe(lnk.mdioCtlOe), .mdioDev(lnk.mdioDev), .mdioDevOe(lnk.mdioDevOe));
  // clock
  always #10 core_clk = ~core_clk;
  function logic [15:0] pat(input logic [4:0] a, input logic [15:0] b);
    return {a[3:0], b[11:0]} ^ 16'h3C5A;
  endfunction
  // user-side registers; data garbled outside the valid cycle
  always @(posedge core_clk) accRdata <= accRd ? pat(accSel, accAddr) : ~accRdata;
  always @(posedge core_clk) pend <= regRd;
  task cmp(input logic [36:0] gv, xv, input bit c);
    total_checks += c;
    if (gv !== xv)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, gv, xv);
    end
  endtask
  // results against oldest notes
  always @(negedge core_clk)
  begin
    if (pend)
    begin
      e = qr.pop_front();
      cmp(37'(regRdata & e[31:16]), 37'(e[15:0]), e[31:16] != 0);
    end
    if (accWr)
      cmp({accSel, accAddr, accWdata}, qw.size() ? qw.pop_front() : '1, 1);
  end
  task finish_test;
    if (qw.size() != 0)
    begin
      num_errors++;
      $display("wrong value at %0t: %0d writes never seen", $time, qw.size());
    end
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [15:0] x);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= x;
    regWr <= w;
    regRd <= !w;
    @(posedge core_clk);
    regWr <= 0;
    regRd <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] m, x);
    qr.push_back({m, x});
    bus(0, a, 16'h0);
    @(negedge core_clk) last = regRdata;
  endtask
  // poll status until neither quiet nor busy
  task idle;
    n = 0;
    last = 16'h3;
    while (last[1:0] != 0 && n < 3000)
    begin
      rd(4'h2, 16'h0, 16'h0);
      n++;
    end
    if (n == 3000)
    begin
      num_errors++;
      $display("wrong value at %0t: link stays busy", $time);
      finish_test;
    end
  endtask
  task frm(input logic r, input logic [4:0] a, input logic [15:0] x, m, y, input logic [4:0] ph = 5'h05);
    idle;
    bus(1, 4'h1, x);
    bus(1, 4'h0, {5'h0, r, ph, a});
    idle;
    if (r)
      rd(4'h3, m, y);
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1;
    g = 5'h10 | 5'($random(seed) & 15);
    d = $random(seed);
    qw.push_back({5'h0, 11'h0, g, d});
    frm(0, g, d, 0, 0);
    frm(1, g, 0, 16'hFFFF, pat(5'h0, 16'(g)));
    $display("direct done");
    foreach (tab[i])
    begin
      s = tab[i][20:16];
      p = tab[i][15:0] ? tab[i][15:0] : 16'h0400 | 16'($random(seed));
      v = s inside {5'h1F, 5'h03, 5'h07};
      ok = v && !(s == 5'h1F && p inside {16'hD, 16'hE});
      ms = (s == 5'h1F && p < 32) ? 5'h0 : s;
      d = $random(seed);
      frm(0, 5'h0D, {11'h0, s}, 0, 0);
      frm(0, 5'h0E, p, 0, 0);
      frm(1, 5'h0E, 0, 16'hFFFF, v ? p : 16'h0);
      frm(1, 5'h0D, 0, 16'hFFFF, {11'h0, s});
      frm(0, 5'h0D, {11'h200, s}, 0, 0);
      if (ok)
        qw.push_back({ms, p, d});
      frm(0, 5'h0E, d, 0, 0);
      repeat (2) frm(1, 5'h0E, 0, 16'hFFFF, ok ? pat(ms, p) : 16'h0);
      $display("window case %0d done", i);
    end
    bus(1, 4'h1, d);
    rd(4'h1, 16'hFFFF, d);
    bus(1, 4'h4, 16'h0);
    rd(4'h2, 16'h0003, 16'h0001);
    $display("quiet restart done");
    frm(0, 5'h0D, 16'h801F, 0, 0);
    frm(0, 5'h0E, d, 0, 0);
    frm(1, 5'h0E, 0, 16'hFFFF, 16'h0);
    $display("unknown function done");
    frm(0, g, d, 0, 0, 5'h04);
    frm(1, g, 0, 0, 0, 5'h04);
    rd(4'h2, 16'h0004, 16'h0004);
    $display("foreign address done");
    finish_test;
  end
endmodule
